// [verilog/sld_pkg.sv]
// Function
// - Generate panel drive timing and hold the pixel data shown on the glass.
// - Drive up to eight common lines and up to 46 segment lines.
// - Multiplex setting selects one to eight commons; 1/N cycles through N commons.
// - Static bias always; half bias only with two commons; third bias with three or more.
// - With eight commons one segment pin carries the eighth common, leaving 45 segments.
// - Control bit 7 switches the whole display module on or off.
// - With control bit 6 cleared the panel keeps being driven during sleep.
// - Two selectable LCD clock sources, the chosen one followed by a software-set prescaler.
// - Phase register holds prescaler setting and Type-A or Type-B waveform choice.
// - A set segment enable bit makes that pin an LCD output, overriding other functions.
// - Each pixel bit belongs to one segment and common pair and sets clear or dark.
package sld_pkg;

	localparam int SLD_SEGS      = 46;
	localparam int SLD_COMS      = 8;
	localparam int SLD_SEG_REGS  = 6;
	localparam int SLD_DATA_REGS = 48;
	localparam int SLD_ADR_W     = 9;
	localparam int SLD_PRE_W     = 4;

	// Byte addresses of the byte-wide registers, one per 32-bit word
	localparam logic [8:0] SLD_CTRL_OFS   = 9'h000;
	localparam logic [8:0] SLD_PHASE_OFS  = 9'h004;
	localparam logic [8:0] SLD_STAT_OFS   = 9'h008;
	localparam logic [8:0] SLD_SEGEN_OFS  = 9'h010;
	localparam logic [8:0] SLD_SEGEN_END  = 9'h028;
	localparam logic [8:0] SLD_DATA_OFS   = 9'h040;
	localparam logic [8:0] SLD_DATA_END   = 9'h100;

	// Control register fields
	localparam int SLD_EN_BIT     = 7;
	localparam int SLD_SLP_BIT    = 6;
	localparam int SLD_CLKSEL_BIT = 5;
	localparam int SLD_BIAS_LSB   = 3;
	localparam int SLD_MUX_LSB    = 0;
	// Phase register fields
	localparam int SLD_WAVE_BIT   = 7;
	localparam int SLD_PRE_LSB    = 0;
	// Status register fields
	localparam int SLD_ACT_BIT    = 7;
	localparam int SLD_NEG_BIT    = 6;

	localparam logic [7:0] SLD_CTRL_RST  = 8'h00;
	localparam logic [7:0] SLD_PHASE_RST = 8'h00;
	localparam logic [7:0] SLD_REG_RST   = 8'h00;
	localparam logic [2:0] SLD_MUX_MAX   = 3'h7;

	typedef enum logic [1:0] {
		SLD_BIAS_STATIC,
		SLD_BIAS_HALF,
		SLD_BIAS_THIRD
	} sld_bias_e;

	// Bias rail codes, V0 lowest
	localparam logic [1:0] SLD_V0 = 2'h0;
	localparam logic [1:0] SLD_V1 = 2'h1;
	localparam logic [1:0] SLD_V2 = 2'h2;
	localparam logic [1:0] SLD_V3 = 2'h3;

	// Pixel byte holding segment seg on common com
	function automatic logic [5:0] sld_pix_index(input logic [2:0] com, input int seg);
		sld_pix_index = 6'(int'(com) * SLD_SEG_REGS + seg / 8);
	endfunction

endpackage

// [verilog/sld_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
module sld_prescaler (
	input  wire logic                       clock,     // System clock
	input  wire logic                       reset,     // Async reset, high
	input  wire logic                       src_a,     // LCD clock source 0 pin
	input  wire logic                       src_b,     // LCD clock source 1 pin
	input  wire logic                       src_sel,   // Source select
	input  wire logic [sld_pkg::SLD_PRE_W-1:0] ratio,  // Divide by ratio+1
	input  wire logic                       run,       // Module active
	output logic                            tick       // One-cycle phase step
);
	import sld_pkg::*;

	logic [2:0]           sync_a;
	logic [2:0]           sync_b;
	logic [SLD_PRE_W-1:0] count;
	wire                  edge_a   = sync_a[1] & ~sync_a[2];
	wire                  edge_b   = sync_b[1] & ~sync_b[2];
	wire                  src_edge = src_sel ? edge_b : edge_a;
	wire                  at_end   = (count >= ratio);

	// Pins are asynchronous; stage 0 feeds only stage 1
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sync_a <= 3'h0;
			sync_b <= 3'h0;
		end else begin
			sync_a <= {sync_a[1:0], src_a};
			sync_b <= {sync_b[1:0], src_b};
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			count <= '0;
			tick  <= 1'b0;
		end else if (!run) begin
			count <= '0;
			tick  <= 1'b0;
		end else begin
			tick <= src_edge & at_end;
			if (src_edge)
				count <= at_end ? '0 : count + 1'b1;
		end
	end

	chk_tick_ratio: assert property (@(posedge clock) disable iff (reset)
		(run && src_edge && !at_end) |=> !tick)
		else $error("prescaler ticked before its count was reached");

endmodule // sld_prescaler
`default_nettype wire

// [verilog/sld_drive.sv]
`timescale 1ns/1ps
`default_nettype none
module sld_drive #(
	parameter int SEGS = 46,
	parameter int COMS = 8
) (
	input  wire logic              clock,      // System clock
	input  wire logic              reset,      // Async reset, high
	input  wire logic              run,        // Module active
	input  wire logic              tick,       // Phase step
	input  wire logic [2:0]        ncom_m1,    // Commons in use minus one
	input  wire logic              wave_b,     // Type-B waveform
	input  wire sld_pkg::sld_bias_e bias,      // Effective bias
	input  wire logic [SEGS-1:0]   row,        // Pixels of current common
	output logic [2:0]             com_idx,    // Current common
	output logic                   neg,        // Negative drive phase
	output logic [COMS*2-1:0]      com_level,  // Rail code per common
	output logic [SEGS*2-1:0]      seg_level   // Rail code per segment
);
	import sld_pkg::*;

	function automatic logic [1:0] com_lvl(input logic sel, input sld_bias_e b, input logic n);
		if (sel || b == SLD_BIAS_STATIC)
			com_lvl = n ? SLD_V0 : ((b == SLD_BIAS_HALF) ? SLD_V2 : SLD_V3);
		else if (b == SLD_BIAS_HALF)
			com_lvl = SLD_V1;
		else
			com_lvl = n ? SLD_V2 : SLD_V1;
	endfunction

	function automatic logic [1:0] seg_lvl(input logic on, input sld_bias_e b, input logic n);
		logic [1:0] top;
		top = (b == SLD_BIAS_HALF) ? SLD_V2 : SLD_V3;
		if (on)
			seg_lvl = n ? top : SLD_V0;  // Opposite rail to the selected common
		else if (b == SLD_BIAS_THIRD)
			seg_lvl = n ? SLD_V1 : SLD_V2;
		else
			seg_lvl = n ? SLD_V0 : top;
	endfunction

	logic [COMS*2-1:0] next_com_level;
	logic [SEGS*2-1:0] next_seg_level;
	wire               last_com = (com_idx >= ncom_m1);
	wire               full_mux = (ncom_m1 == SLD_MUX_MAX);

	for (genvar c = 0; c < COMS; c++) begin : g_com
		assign next_com_level[c*2 +: 2] = (c > int'(ncom_m1)) ? SLD_V0 :
			com_lvl(com_idx == 3'(c), bias, neg);
	end
	for (genvar s = 0; s < SEGS; s++) begin : g_seg
		if (s == SEGS - 1) begin : g_shared
			// This pin turns into the eighth common at full multiplex
			assign next_seg_level[s*2 +: 2] = full_mux ?
				next_com_level[(COMS-1)*2 +: 2] : seg_lvl(row[s], bias, neg);
		end else begin : g_plain
			assign next_seg_level[s*2 +: 2] = seg_lvl(row[s], bias, neg);
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			com_idx <= 3'h0;
			neg     <= 1'b0;
		end else if (!run) begin
			com_idx <= 3'h0;
			neg     <= 1'b0;
		end else if (tick) begin
			if (!wave_b) begin
				neg <= ~neg;
				if (neg)
					com_idx <= last_com ? 3'h0 : com_idx + 3'h1;
			end else begin
				com_idx <= last_com ? 3'h0 : com_idx + 3'h1;
				if (last_com)
					neg <= ~neg;
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			com_level <= '0;
			seg_level <= '0;
		end else begin
			com_level <= run ? next_com_level : '0;
			seg_level <= run ? next_seg_level : '0;
		end
	end

	chk_hold_off: assert property (@(posedge clock) disable iff (reset)
		!run |=> (com_idx == 3'h0 && com_level == '0 && seg_level == '0))
		else $error("outputs or sequence moved while disabled");
	chk_com_wrap: assert property (@(posedge clock) disable iff (reset)
		(run && tick && wave_b && com_idx >= ncom_m1) |=> (com_idx == 3'h0 && neg != $past(neg)))
		else $error("common sequence did not wrap at the last common");
	chk_typea_flip: assert property (@(posedge clock) disable iff (reset)
		(run && tick && !wave_b) |=> (neg != $past(neg)))
		else $error("Type-A phase did not alternate");
	chk_seg_shared: assert property (@(posedge clock) disable iff (reset)
		$past(run && full_mux) |-> (seg_level[(SEGS-1)*2 +: 2] == com_level[(COMS-1)*2 +: 2]))
		else $error("shared pin does not carry the eighth common");
	cov_typeb_frame: cover property (@(posedge clock) disable iff (reset)
		run && wave_b && tick && last_com);
	cov_full_mux: cover property (@(posedge clock) disable iff (reset)
		run && full_mux && com_idx == SLD_MUX_MAX);

endmodule // sld_drive
`default_nettype wire

// [verilog/sld_top.sv]
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sld_top (
	input  wire logic                            clock,          // 20 MHz system clock
	input  wire logic                            reset,          // Async reset, high
	input  wire logic                            wb_cyc,         // Wishbone cycle
	input  wire logic                            wb_stb,         // Wishbone strobe
	input  wire logic                            wb_we,          // Wishbone write
	input  wire logic [sld_pkg::SLD_ADR_W-1:0]   wb_adr,         // Byte address
	input  wire logic [3:0]                      wb_sel,         // Byte lanes
	input  wire logic [31:0]                     wb_dat_i,       // Write data
	output logic [31:0]                          wb_dat_o,       // Read data
	output logic                                 wb_ack,         // Acknowledge
	input  wire logic                            sleep,          // Core in sleep
	input  wire logic                            lcd_clk_a,      // LCD clock source 0
	input  wire logic                            lcd_clk_b,      // LCD clock source 1
	output logic [sld_pkg::SLD_COMS*2-1:0]       com_level,      // Common rail codes
	output logic [sld_pkg::SLD_SEGS*2-1:0]       seg_level,      // Segment rail codes
	output logic [sld_pkg::SLD_SEGS-1:0]         pin_lcd_mode    // Pin owned by LCD
);
	import sld_pkg::*;

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	logic [7:0]          display_control_reg;
	logic [7:0]          phase_prescale_reg;
	logic [7:0]          segment_enable_regs [SLD_SEG_REGS];
	logic [7:0]          pixel_data_regs     [SLD_DATA_REGS];
	logic [SLD_SEGS-1:0] seg_en_vec;
	logic [SLD_SEGS-1:0] cur_row;
	logic [2:0]          com_idx;
	logic                neg;
	logic                tick;

	// ----------------------------------------------------------------
	// Control decode
	// ----------------------------------------------------------------
	wire        display_enable_bit = display_control_reg[SLD_EN_BIT];
	wire        sleep_run_control  = display_control_reg[SLD_SLP_BIT];
	wire [2:0]  ncom_m1   = display_control_reg[SLD_MUX_LSB +: 3];
	wire [1:0]  bias_req  = display_control_reg[SLD_BIAS_LSB +: 2];
	wire        clk_sel   = display_control_reg[SLD_CLKSEL_BIT];
	wire        wave_b    = phase_prescale_reg[SLD_WAVE_BIT];
	wire [SLD_PRE_W-1:0] pre_ratio = phase_prescale_reg[SLD_PRE_LSB +: SLD_PRE_W];

	// Sleep only halts the panel when software asked for that
	wire        active = display_enable_bit & ~(sleep & sleep_run_control);

	// Illegal bias choices fall back to static so the glass never sees
	// a ladder that does not match the common count
	wire        half_ok  = (ncom_m1 == 3'h1);
	wire        third_ok = (ncom_m1 >= 3'h2);
	sld_bias_e  eff_bias;
	assign eff_bias = (bias_req == 2'(SLD_BIAS_HALF)  && half_ok)  ? SLD_BIAS_HALF :
	                  (bias_req == 2'(SLD_BIAS_THIRD) && third_ok) ? SLD_BIAS_THIRD :
	                  SLD_BIAS_STATIC;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire        req       = wb_cyc & wb_stb & ~wb_ack;
	wire        wr        = req & wb_we & wb_sel[0];
	wire        aligned   = (wb_adr[1:0] == 2'h0);
	wire        hit_ctrl  = aligned && (wb_adr == SLD_CTRL_OFS);
	wire        hit_phase = aligned && (wb_adr == SLD_PHASE_OFS);
	wire        hit_stat  = aligned && (wb_adr == SLD_STAT_OFS);
	wire        hit_segen = aligned && (wb_adr >= SLD_SEGEN_OFS) && (wb_adr < SLD_SEGEN_END);
	wire        hit_data  = aligned && (wb_adr >= SLD_DATA_OFS) && (wb_adr < SLD_DATA_END);
	wire [8:0]  segen_off = wb_adr - SLD_SEGEN_OFS;
	wire [8:0]  data_off  = wb_adr - SLD_DATA_OFS;
	wire [2:0]  segen_idx = segen_off[4:2];
	wire [5:0]  data_idx  = data_off[7:2];
	wire [7:0]  stat_val  = {active, neg, 1'b0, 2'(eff_bias), com_idx};
	wire [7:0]  rd_byte   = hit_ctrl  ? display_control_reg :
	                        hit_phase ? phase_prescale_reg :
	                        hit_stat  ? stat_val :
	                        hit_segen ? segment_enable_regs[segen_idx] :
	                        hit_data  ? pixel_data_regs[data_idx] :
	                        8'h00;

	// ----------------------------------------------------------------
	// Pixel and segment enable flattening
	// ----------------------------------------------------------------
	for (genvar s = 0; s < SLD_SEGS; s++) begin : g_flat
		assign seg_en_vec[s] = segment_enable_regs[s / 8][s % 8];
		assign cur_row[s]    = pixel_data_regs[sld_pix_index(com_idx, s)][s % 8];
	end

	// ----------------------------------------------------------------
	// Wishbone slave
	// ----------------------------------------------------------------
	// Every access, mapped or not, is answered one cycle after it is seen;
	// unmapped reads return zero and unmapped writes are dropped
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wb_ack   <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack   <= req;
			wb_dat_o <= req ? {24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			display_control_reg <= SLD_CTRL_RST;
			phase_prescale_reg  <= SLD_PHASE_RST;
		end else begin
			if (wr && hit_ctrl)
				display_control_reg <= wb_dat_i[7:0];
			if (wr && hit_phase)
				phase_prescale_reg <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < SLD_SEG_REGS; i++)
				segment_enable_regs[i] <= SLD_REG_RST;
		end else if (wr && hit_segen) begin
			segment_enable_regs[segen_idx] <= wb_dat_i[7:0];
		end
	end

	// Pixel store: byte index = common * 6 + segment / 8
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < SLD_DATA_REGS; i++)
				pixel_data_regs[i] <= SLD_REG_RST;
		end else if (wr && hit_data) begin
			pixel_data_regs[data_idx] <= wb_dat_i[7:0];
		end
	end

	// Pin ownership follows the enable bits regardless of run state,
	// so the pin function does not jump when the display toggles
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			pin_lcd_mode <= '0;
		else
			pin_lcd_mode <= seg_en_vec;
	end

	// ----------------------------------------------------------------
	// Clocking and waveform engine
	// ----------------------------------------------------------------
	sld_prescaler u_pre (
		.clock   (clock),
		.reset   (reset),
		.src_a   (lcd_clk_a),
		.src_b   (lcd_clk_b),
		.src_sel (clk_sel),
		.ratio   (pre_ratio),
		.run     (active),
		.tick    (tick)
	);

	sld_drive #(
		.SEGS (SLD_SEGS),
		.COMS (SLD_COMS)
	) u_drive (
		.clock     (clock),
		.reset     (reset),
		.run       (active),
		.tick      (tick),
		.ncom_m1   (ncom_m1),
		.wave_b    (wave_b),
		.bias      (eff_bias),
		.row       (cur_row),
		.com_idx   (com_idx),
		.neg       (neg),
		.com_level (com_level),
		.seg_level (seg_level)
	);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_ack_pulse: assert property (@(posedge clock) disable iff (reset)
		wb_ack |=> !wb_ack)
		else $error("acknowledge held longer than one cycle");
	chk_ack_timely: assert property (@(posedge clock) disable iff (reset)
		(wb_cyc && wb_stb && !wb_ack) |=> wb_ack)
		else $error("request not answered in one cycle");
	chk_ctrl_write: assert property (@(posedge clock) disable iff (reset)
		(wr && hit_ctrl) |=> (display_control_reg == $past(wb_dat_i[7:0])))
		else $error("control write not stored");
	chk_sleep_run: assert property (@(posedge clock) disable iff (reset)
		(display_enable_bit && !sleep_run_control) |-> active)
		else $error("panel stopped though sleep running was chosen");
	chk_sleep_halt: assert property (@(posedge clock) disable iff (reset)
		(sleep && sleep_run_control) |=> (com_level == '0 && seg_level == '0))
		else $error("panel driven during sleep halt");
	chk_bias_legal: assert property (@(posedge clock) disable iff (reset)
		(eff_bias == SLD_BIAS_HALF |-> ncom_m1 == 3'h1) and
		(eff_bias == SLD_BIAS_THIRD |-> ncom_m1 >= 3'h2))
		else $error("bias used with a common count it does not allow");
	chk_pin_owner: assert property (@(posedge clock) disable iff (reset)
		##1 (pin_lcd_mode == $past(seg_en_vec)))
		else $error("pin ownership does not follow segment enables");
	chk_pixel_store: assert property (@(posedge clock) disable iff (reset)
		(wr && hit_data) |=> (pixel_data_regs[$past(data_idx)] == $past(wb_dat_i[7:0])))
		else $error("pixel byte not stored");
	chk_off_quiet: assert property (@(posedge clock) disable iff (reset)
		!display_enable_bit [*2] |-> (com_level == '0 && seg_level == '0))
		else $error("outputs active while module disabled");

	cov_sleep_hold: cover property (@(posedge clock) disable iff (reset)
		display_enable_bit && sleep && sleep_run_control);
	cov_third_bias: cover property (@(posedge clock) disable iff (reset)
		active && eff_bias == SLD_BIAS_THIRD && tick);

endmodule // sld_top
`default_nettype wire

// [tb/sld_panel_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Passive glass: decodes selected common and dark pixels
// ----------------------------------------
module sld_panel_model (
	input  wire logic [15:0] com_level,  // Common rail codes
	input  wire logic [91:0] seg_level,  // Segment rail codes
	input  wire logic [2:0]  n_used,     // Commons wired on the glass minus one
	output logic [2:0]       act_com,    // Selected common
	output logic             act_pos,    // Positive drive phase
	output logic             act_valid,  // Panel is being driven
	output logic [45:0]      dark        // Pixels of the selected common shown dark
);
	logic [2:0] top_c;
	logic [1:0] top_v;

	// Unused commons sit at rail 0, so only wired ones may be looked at
	always_comb begin
		act_pos = 1'b1;
		act_com = 3'h0;
		top_c   = 3'h0;
		top_v   = 2'h0;
		for (int c = 0; c < 8; c++) begin
			if (c <= int'(n_used) && com_level[c*2+:2] == 2'h0) begin
				act_pos = 1'b0;
				act_com = 3'(c);
			end
			if (c <= int'(n_used) && com_level[c*2+:2] > top_v) begin
				top_v = com_level[c*2+:2];
				top_c = 3'(c);
			end
		end
		if (act_pos)
			act_com = top_c;
		for (int s = 0; s < 46; s++)
			// The top rail in the negative phase is V2 under half bias, V3 otherwise
			dark[s] = act_pos ? (seg_level[s*2+:2] == 2'h0) : seg_level[s*2+1];
	end

	assign act_valid = (|com_level) || (|seg_level);
endmodule // sld_panel_model
`default_nettype wire

// [tb/segment_lcd_drive_control_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module segment_lcd_drive_control_bench;
	import sld_pkg::*;
	logic        clock, reset, wb_cyc, wb_stb, wb_we, wb_ack, sleep, lcd_clk_a, lcd_clk_b;
	logic [8:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic [15:0] com_level;
	logic [91:0] seg_level;
	logic [45:0] pin_lcd_mode, dark;
	logic [47:0] seg_en;
	logic [2:0]  n_used, act_com;
	logic        act_pos, act_valid;
	logic [7:0]  pix [48];
	int          num_errors, check_count, seed;

	sld_top DUT (.clock(clock), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
		.wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack(wb_ack), .sleep(sleep), .lcd_clk_a(lcd_clk_a), .lcd_clk_b(lcd_clk_b),
		.com_level(com_level), .seg_level(seg_level), .pin_lcd_mode(pin_lcd_mode));
	sld_panel_model glass (.com_level(com_level), .seg_level(seg_level), .n_used(n_used),
		.act_com(act_com), .act_pos(act_pos), .act_valid(act_valid), .dark(dark));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Longest run is about 5000 cycles
	initial begin
		repeat (40000) @(posedge clock);
		num_errors++;
		report_and_stop;
	end

	// ----------------------------------------
	// Compare and bus tasks
	// ----------------------------------------
	task automatic check_reg(input string what, input logic [7:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== {24'h0, exp}) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check_bits(input string what, input logic [91:0] exp, input logic [91:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic bus(input logic we, input logic [8:0] adr, input logic [7:0] dat,
			input logic sel0);
		int n;
		n = 0;
		@(posedge clock);
		wb_cyc   <= 1'b1;
		wb_stb   <= 1'b1;
		wb_we    <= we;
		wb_adr   <= adr;
		wb_dat_i <= {24'h0, dat};
		wb_sel   <= {3'h7, sel0};
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack !== 1'b1 && n < 16);
		rd = wb_dat_o;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		// A missing answer ends the run at once
		if (n >= 16) begin
			check_bits("bus ack", 92'h1, 92'h0);
			report_and_stop;
		end
	endtask

	task automatic wr(input logic [8:0] adr, input logic [7:0] dat);
		bus(1'b1, adr, dat, 1'b1);
	endtask

	task automatic rd_chk(input logic [8:0] adr, input logic [7:0] exp);
		bus(1'b0, adr, 8'h00, 1'b1);
		check_reg($sformatf("register %h", adr), exp, rd);
	endtask

	// One rising edge on the chosen source, then time for the step to land
	task automatic lcd_step(input logic use_b);
		@(posedge clock);
		lcd_clk_a <= ~use_b;
		lcd_clk_b <= use_b;
		repeat (4) @(posedge clock);
		lcd_clk_a <= 1'b0;
		lcd_clk_b <= 1'b0;
		repeat (8) @(posedge clock);
	endtask

	function automatic logic [45:0] exp_row(input logic [2:0] c);
		for (int s = 0; s < 46; s++)
			exp_row[s] = pix[int'(c) * 6 + s / 8][s % 8];
	endfunction

	// ----------------------------------------
	// Drive sequence for one configuration
	// ----------------------------------------
	task automatic run_mux(input int n, input logic [1:0] bias, input logic wave_b,
			input logic src, input logic [3:0] pre);
		logic [2:0]  ec;
		logic        ep;
		logic [1:0]  eb;
		logic [45:0] mask;
		eb = (bias == 2'h1 && n == 2) ? 2'h1 : (bias == 2'h2 && n >= 3) ? 2'h2 : 2'h0;
		mask = {n != 8, 45'h1FFF_FFFF_FFFF};
		n_used = 3'(n - 1);
		wr(SLD_CTRL_OFS, 8'h00);
		wr(SLD_PHASE_OFS, {wave_b, 3'h0, pre});
		wr(SLD_CTRL_OFS, {2'h2, src, bias, 3'(n - 1)});
		bus(1'b0, SLD_STAT_OFS, 8'h00, 1'b1);
		check_reg("status bias", {1'b1, 2'h0, eb, 3'h0}, rd & 32'h98);
		// Static fallback drives every common alike, so step with a legal ladder
		if (eb == 2'h0 && n > 1)
			wr(SLD_CTRL_OFS, {2'h2, src, (n == 2) ? 2'h1 : 2'h2, 3'(n - 1)});
		repeat (int'(pre) + 1) lcd_step(src);
		check_bits("driving", 92'h1, 92'(act_valid));
		for (int k = 0; k < 2 * n; k++) begin
			ec = act_com;
			ep = act_pos;
			lcd_step(~src);
			repeat (int'(pre)) lcd_step(src);
			check_bits("held step", {ec, ep}, {act_com, act_pos});
			lcd_step(src);
			if (wave_b) begin
				ep = (ec == 3'(n - 1)) ? ~ep : ep;
				ec = (ec == 3'(n - 1)) ? 3'h0 : ec + 3'h1;
			end else begin
				ec = ep ? ec : (ec == 3'(n - 1)) ? 3'h0 : ec + 3'h1;
				ep = ~ep;
			end
			check_bits("common step", {ec, ep}, {act_com, act_pos});
			check_bits("pixels", exp_row(ec) & mask, dark & mask);
			if (n == 8)
				check_bits("seg 45", 92'(com_level[15:14]), 92'(seg_level[91:90]));
		end
		$display("test mux %0d done", n);
	endtask

	initial begin
		logic [7:0] v;
		seed = 32'h2BCB18FB;
		reset = 1'b1;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 9'h000;
		wb_sel = 4'h0;
		wb_dat_i = 32'h0;
		sleep = 1'b0;
		lcd_clk_a = 1'b0;
		lcd_clk_b = 1'b0;
		n_used = 3'h7;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		check_bits("reset levels", 92'h0, seg_level | 92'(com_level));
		rd_chk(SLD_CTRL_OFS, SLD_CTRL_RST);
		rd_chk(SLD_PHASE_OFS, SLD_PHASE_RST);
		rd_chk(SLD_STAT_OFS, SLD_REG_RST);
		$display("test reset done");
		for (int k = 0; k < 6; k++) begin
			v = 8'($random(seed)) & (k == 5 ? 8'h3F : 8'hFF);
			seg_en[k*8+:8] = v;
			wr(SLD_SEGEN_OFS + 9'(k * 4), v);
			rd_chk(SLD_SEGEN_OFS + 9'(k * 4), v);
		end
		check_bits("pin_lcd_mode", 92'(seg_en[45:0]), 92'(pin_lcd_mode));
		for (int i = 0; i < 48; i++) begin
			pix[i] = 8'($random(seed)) & (i % 6 == 5 ? 8'h3F : 8'hFF);
			wr(SLD_DATA_OFS + 9'(i * 4), pix[i]);
		end
		for (int i = 0; i < 48; i += 5)
			rd_chk(SLD_DATA_OFS + 9'(i * 4), pix[i]);
		wr(9'h030, 8'h5A);
		rd_chk(9'h030, 8'h00);
		rd_chk(9'h041, 8'h00);
		wr(SLD_STAT_OFS, 8'hFF);
		rd_chk(SLD_STAT_OFS, 8'h00);
		bus(1'b1, SLD_PHASE_OFS, 8'h8F, 1'b0);
		rd_chk(SLD_PHASE_OFS, 8'h00);
		repeat (2) lcd_step(1'b0);
		check_bits("idle levels", 92'h0, seg_level | 92'(com_level));
		$display("test registers done");
		run_mux(2, 2'h1, 1'b0, 1'b0, 4'h0);
		run_mux(3, 2'h2, 1'b1, 1'b1, 4'h2);
		run_mux(8, 2'h1, 1'b0, 1'b0, 4'h1);
		for (int n = 1; n <= 8; n++)
			run_mux(n, 2'($unsigned($random(seed)) % 3), 1'($random(seed)),
				1'($random(seed)), 4'($unsigned($random(seed)) % 3));
		sleep <= 1'b1;
		run_mux(4, 2'h2, 1'b0, 1'b0, 4'h0);
		// Enable, stop in sleep, four commons, third bias
		wr(SLD_CTRL_OFS, 8'hD3);
		repeat (2) lcd_step(1'b0);
		check_bits("sleep halt", 92'h0, seg_level | 92'(com_level));
		sleep <= 1'b0;
		$display("test sleep done");
		run_mux(5, 2'h2, 1'b1, 1'b0, 4'h0);
		wr(SLD_CTRL_OFS, 8'h14);
		repeat (2) lcd_step(1'b0);
		check_bits("disabled", 92'h0, seg_level | 92'(com_level));
		$display("test disable done");
		report_and_stop;
	end
endmodule // segment_lcd_drive_control_bench
`default_nettype wire
